// ===== design/ceim_consts.svh
// constants for the extended interrupt mask block
`ifndef CEIM_CONSTS_SVH
`define CEIM_CONSTS_SVH

// bus geometry
`define CEIM_ADDR_W 8
`define CEIM_DATA_W 32
`define CEIM_STRB_W 4

// register byte offsets
`define CEIM_OFF_STATUS 8'h18
`define CEIM_OFF_MASK 8'h1c

// reset values
`define CEIM_MASK_RST 32'h0000_0000
`define CEIM_STATUS_RST 32'h0000_0000

// implemented enable bits: 2,3,4,6,8,10-14,16-22,24-26,29-31
`define CEIM_MASK_IMPL 32'he77f_7d5c
// status flags that may raise a request (group bit 2 is not a flag)
`define CEIM_FLAG_IMPL 32'he77f_7d58

// field positions
`define CEIM_GRP_BIT 2
`define CEIM_ASYNC_RX_AVAIL_BIT 3
`define CEIM_ISO_RX_AVAIL_BIT 4
`define CEIM_VIDEO_RX_AVAIL_BIT 6
`define CEIM_VIDEO_RELEASE_BIT 8
`define CEIM_CPU_ACCESS_ERR_BIT 10
`define CEIM_OVERLAP_ACCESS_BIT 11
`define CEIM_ASYNC_BULK_PURGE_BIT 12
`define CEIM_HANDSHAKE_TMO_BIT 13
`define CEIM_ISO_BULK_PURGE_BIT 14
`define CEIM_VIDEO_BULK_PURGE_BIT 16
`define CEIM_ASYNC_CTRL_CONFIRM_BIT 17
`define CEIM_ASYNC_CTRL_PURGE_BIT 18
`define CEIM_BCAST_CTRL_CONFIRM_BIT 19
`define CEIM_BCAST_CTRL_PURGE_BIT 20
`define CEIM_SELFID_END_BIT 21
`define CEIM_SELFID_PURGE_BIT 22
`define CEIM_CPU_REFUSED_BIT 24
`define CEIM_EARLY_ISO_GO_BIT 25
`define CEIM_TX_BLOCK_COUNT_BIT 26
`define CEIM_BULK_TX_DONE_BIT 29
`define CEIM_BULK_TX_FAIL_BIT 30
`define CEIM_RX_BLOCK_COUNT_BIT 31

// bus response codes
`define CEIM_RESP_OKAY 2'h0
`define CEIM_RESP_SLVERR 2'h2

`endif

// ===== design/ceim_pkg.sv
// types for the extended interrupt mask block
`include "ceim_consts.svh"

package ceim_pkg;

  // AXI4-Lite signals driven by the master
  typedef struct packed {
    logic awvalid;
    logic [`CEIM_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [`CEIM_DATA_W-1:0] wdata;
    logic [`CEIM_STRB_W-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`CEIM_ADDR_W-1:0] araddr;
    logic rready;
  } ceim_axi_req_t;

  // AXI4-Lite signals driven by this slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`CEIM_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } ceim_axi_rsp_t;

  // whole state of the block
  typedef struct packed {
    logic aw_held;
    logic [`CEIM_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [`CEIM_DATA_W-1:0] w_data;
    logic [`CEIM_STRB_W-1:0] w_strb;
    ceim_axi_rsp_t rsp;
    logic [`CEIM_DATA_W-1:0] mask;
    logic [`CEIM_DATA_W-1:0] flags;
    logic irq;
  } ceim_state_t;

endpackage

// ===== design/ceim_top.sv
// extended interrupt mask with its status flags behind an AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
module ceim_top
  import ceim_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic [`CEIM_DATA_W-1:0] event_i,
  input wire logic primary_irq_i,
  input wire ceim_axi_req_t axi_req_i,
  output ceim_axi_rsp_t axi_rsp_o,
  output logic irq_o
);

  ceim_state_t state_ff;
  ceim_state_t nxt_state;

  // byte strobes widened to a bit mask, used by both register writes
  function automatic logic [`CEIM_DATA_W-1:0] strb_bits(
    input logic [`CEIM_STRB_W-1:0] strb
  );
    logic [`CEIM_DATA_W-1:0] bits;
    bits = '0;
    for (int i = 0; i < `CEIM_STRB_W; i++) begin
      bits[i*8 +: 8] = {8{strb[i]}};
    end
    return bits;
  endfunction

  // word match ignoring the byte lane bits, for reads and writes alike
  function automatic logic hit(
    input logic [`CEIM_ADDR_W-1:0] addr,
    input logic [`CEIM_ADDR_W-1:0] off
  );
    return addr[`CEIM_ADDR_W-1:2] == off[`CEIM_ADDR_W-1:2];
  endfunction

  // one flag through its own enable; every group below reuses it
  function automatic logic gate_bit(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m,
    input int pos
  );
    return f[pos] & m[pos];
  endfunction

  // receive data available on the three receive paths
  // kept per bit so a wrong position shows up as one dead source
  function automatic logic [`CEIM_DATA_W-1:0] rx_avail_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // async receive path
    g[`CEIM_ASYNC_RX_AVAIL_BIT] = gate_bit(f, m, `CEIM_ASYNC_RX_AVAIL_BIT);
    // iso receive path
    g[`CEIM_ISO_RX_AVAIL_BIT] = gate_bit(f, m, `CEIM_ISO_RX_AVAIL_BIT);
    // video receive path
    g[`CEIM_VIDEO_RX_AVAIL_BIT] = gate_bit(f, m, `CEIM_VIDEO_RX_AVAIL_BIT);
    return g;
  endfunction

  // video release timer, also the frame start marker
  // software often leaves it off: it fires once per frame
  function automatic logic [`CEIM_DATA_W-1:0] release_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // cell release
    g[`CEIM_VIDEO_RELEASE_BIT] = gate_bit(f, m, `CEIM_VIDEO_RELEASE_BIT);
    return g;
  endfunction

  // illegal cpu buffer access
  // a cleared enable must block it, so no bypass path exists
  function automatic logic [`CEIM_DATA_W-1:0] access_err_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // empty read or full write
    g[`CEIM_CPU_ACCESS_ERR_BIT] = gate_bit(f, m, `CEIM_CPU_ACCESS_ERR_BIT);
    return g;
  endfunction

  // overlapping cpu read or write attempt
  // the flag only records the attempt; the access itself is elsewhere
  function automatic logic [`CEIM_DATA_W-1:0] overlap_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // early second access
    g[`CEIM_OVERLAP_ACCESS_BIT] = gate_bit(f, m, `CEIM_OVERLAP_ACCESS_BIT);
    return g;
  endfunction

  // partial packet purges of the bulk receive buffers
  // bit 15 between them is reserved and skipped on purpose
  function automatic logic [`CEIM_DATA_W-1:0] bulk_purge_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // async bulk buffer
    g[`CEIM_ASYNC_BULK_PURGE_BIT] = gate_bit(f, m, `CEIM_ASYNC_BULK_PURGE_BIT);
    // iso bulk buffer
    g[`CEIM_ISO_BULK_PURGE_BIT] = gate_bit(f, m, `CEIM_ISO_BULK_PURGE_BIT);
    // video bulk buffer
    g[`CEIM_VIDEO_BULK_PURGE_BIT] = gate_bit(f, m, `CEIM_VIDEO_BULK_PURGE_BIT);
    return g;
  endfunction

  // handshake timeout on the cpu interface
  // the timeout count itself lives with the interface, not here
  function automatic logic [`CEIM_DATA_W-1:0] handshake_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // handshake ran out
    g[`CEIM_HANDSHAKE_TMO_BIT] = gate_bit(f, m, `CEIM_HANDSHAKE_TMO_BIT);
    return g;
  endfunction

  // async and broadcast control receive buffers
  // confirm and purge sit side by side for each buffer
  function automatic logic [`CEIM_DATA_W-1:0] ctrl_rx_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // async packet confirmed
    g[`CEIM_ASYNC_CTRL_CONFIRM_BIT] = gate_bit(f, m, `CEIM_ASYNC_CTRL_CONFIRM_BIT);
    // async partial purge
    g[`CEIM_ASYNC_CTRL_PURGE_BIT] = gate_bit(f, m, `CEIM_ASYNC_CTRL_PURGE_BIT);
    // broadcast packet confirmed
    g[`CEIM_BCAST_CTRL_CONFIRM_BIT] = gate_bit(f, m, `CEIM_BCAST_CTRL_CONFIRM_BIT);
    // broadcast partial purge
    g[`CEIM_BCAST_CTRL_PURGE_BIT] = gate_bit(f, m, `CEIM_BCAST_CTRL_PURGE_BIT);
    return g;
  endfunction

  // self-id period end and self-id purge
  // both follow a bus reset, so they tend to arrive close together
  function automatic logic [`CEIM_DATA_W-1:0] selfid_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // period end
    g[`CEIM_SELFID_END_BIT] = gate_bit(f, m, `CEIM_SELFID_END_BIT);
    // partial purge
    g[`CEIM_SELFID_PURGE_BIT] = gate_bit(f, m, `CEIM_SELFID_PURGE_BIT);
    return g;
  endfunction

  // cpu access refused for a higher priority transfer
  // bit 23 below it is reserved
  function automatic logic [`CEIM_DATA_W-1:0] refused_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // buffer busy
    g[`CEIM_CPU_REFUSED_BIT] = gate_bit(f, m, `CEIM_CPU_REFUSED_BIT);
    return g;
  endfunction

  // stream errors: early iso go and block count faults
  // rx block count sits at bit 31, apart from the other two
  function automatic logic [`CEIM_DATA_W-1:0] stream_err_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // premature iso go
    g[`CEIM_EARLY_ISO_GO_BIT] = gate_bit(f, m, `CEIM_EARLY_ISO_GO_BIT);
    // transmit block count
    g[`CEIM_TX_BLOCK_COUNT_BIT] = gate_bit(f, m, `CEIM_TX_BLOCK_COUNT_BIT);
    // receive block count
    g[`CEIM_RX_BLOCK_COUNT_BIT] = gate_bit(f, m, `CEIM_RX_BLOCK_COUNT_BIT);
    return g;
  endfunction

  // bulk async transmit done and failed
  // bits 27 and 28 below them are reserved
  function automatic logic [`CEIM_DATA_W-1:0] bulk_tx_pend(
    input logic [`CEIM_DATA_W-1:0] f,
    input logic [`CEIM_DATA_W-1:0] m
  );
    logic [`CEIM_DATA_W-1:0] g;
    g = '0;
    // packet sent
    g[`CEIM_BULK_TX_DONE_BIT] = gate_bit(f, m, `CEIM_BULK_TX_DONE_BIT);
    // packet failed
    g[`CEIM_BULK_TX_FAIL_BIT] = gate_bit(f, m, `CEIM_BULK_TX_FAIL_BIT);
    return g;
  endfunction

  // next state: bus slave, mask, flags and the interrupt request
  always_comb begin
    logic [`CEIM_DATA_W-1:0] bits;
    logic [`CEIM_DATA_W-1:0] clr;
    logic [`CEIM_DATA_W-1:0] pend;
    logic ext_req;
    bits = '0;
    clr = '0;
    pend = '0;
    ext_req = 1'b0;
    nxt_state = state_ff;

    // address and data are taken independently, in either order
    if (axi_req_i.awvalid && state_ff.rsp.awready) begin
      nxt_state.aw_held = 1'b1;
      nxt_state.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && state_ff.rsp.wready) begin
      nxt_state.w_held = 1'b1;
      nxt_state.w_data = axi_req_i.wdata;
      nxt_state.w_strb = axi_req_i.wstrb;
    end
    if (state_ff.rsp.bvalid && axi_req_i.bready) begin
      nxt_state.rsp.bvalid = 1'b0;
    end

    // perform the write once both halves are here and no response is pending
    if (state_ff.aw_held && state_ff.w_held && !state_ff.rsp.bvalid) begin
      bits = strb_bits(state_ff.w_strb);
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held = 1'b0;
      nxt_state.rsp.bvalid = 1'b1;
      nxt_state.rsp.bresp = `CEIM_RESP_OKAY;
      if (hit(state_ff.aw_addr, `CEIM_OFF_MASK)) begin
        // reserved enable bits never store a one
        nxt_state.mask = ((state_ff.mask & ~bits) | (state_ff.w_data & bits))
                         & `CEIM_MASK_IMPL;
      end else if (hit(state_ff.aw_addr, `CEIM_OFF_STATUS)) begin
        clr = state_ff.w_data & bits; // write one to clear
      end else begin
        nxt_state.rsp.bresp = `CEIM_RESP_SLVERR;
      end
    end

    // hardware events set flags; a set in the clearing cycle wins
    nxt_state.flags = ((state_ff.flags & ~clr) | event_i) & `CEIM_FLAG_IMPL;

    // read channel: one outstanding read, data one cycle after the address
    if (state_ff.rsp.rvalid && axi_req_i.rready) begin
      nxt_state.rsp.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && state_ff.rsp.arready) begin
      nxt_state.rsp.rvalid = 1'b1;
      nxt_state.rsp.rresp = `CEIM_RESP_OKAY;
      if (hit(axi_req_i.araddr, `CEIM_OFF_MASK)) begin
        nxt_state.rsp.rdata = state_ff.mask; // reserved bits already zero
      end else if (hit(axi_req_i.araddr, `CEIM_OFF_STATUS)) begin
        nxt_state.rsp.rdata = state_ff.flags;
      end else begin
        nxt_state.rsp.rdata = '0;
        nxt_state.rsp.rresp = `CEIM_RESP_SLVERR;
      end
    end

    // software reset disables every extended source
    if (soft_reset_i) begin
      nxt_state.mask = `CEIM_MASK_RST;
      nxt_state.flags = `CEIM_STATUS_RST;
    end

    // readies drop while a half is held or a response waits
    nxt_state.rsp.awready = !nxt_state.aw_held && !nxt_state.rsp.bvalid;
    nxt_state.rsp.wready = !nxt_state.w_held && !nxt_state.rsp.bvalid;
    nxt_state.rsp.arready = !nxt_state.rsp.rvalid;

    // gather the gated flags group by group
    // receive available
    pend = rx_avail_pend(nxt_state.flags, nxt_state.mask);
    // release timer
    pend = pend | release_pend(nxt_state.flags, nxt_state.mask);
    // illegal access
    pend = pend | access_err_pend(nxt_state.flags, nxt_state.mask);
    // overlapping access
    pend = pend | overlap_pend(nxt_state.flags, nxt_state.mask);
    // bulk purges
    pend = pend | bulk_purge_pend(nxt_state.flags, nxt_state.mask);
    // handshake timeout
    pend = pend | handshake_pend(nxt_state.flags, nxt_state.mask);
    // control receive buffers
    pend = pend | ctrl_rx_pend(nxt_state.flags, nxt_state.mask);
    // self-id
    pend = pend | selfid_pend(nxt_state.flags, nxt_state.mask);
    // refused access
    pend = pend | refused_pend(nxt_state.flags, nxt_state.mask);
    // stream errors
    pend = pend | stream_err_pend(nxt_state.flags, nxt_state.mask);
    // bulk transmit
    pend = pend | bulk_tx_pend(nxt_state.flags, nxt_state.mask);
    // reserved positions can never pend
    pend = pend & `CEIM_FLAG_IMPL;
    // extended part needs a pending flag and the group route
    ext_req = nxt_state.mask[`CEIM_GRP_BIT] && (|pend);
    // primary source passes whatever the group bit says
    nxt_state.irq = primary_irq_i || ext_req;
  end

  // single state register; power-up clears everything
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs come straight from the state register
  assign axi_rsp_o = state_ff.rsp;
  assign irq_o = state_ff.irq;

endmodule

// ===== tb/ceim_host.sv
// host side model: counts interrupt requests seen on the pin
module ceim_host (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic irq_i,
  output logic [7:0] rises_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_ff;
  // level pin, so only a new request counts
  always_ff @(posedge core_clk_i) begin
    irq_ff <= irq_i & reset_n_i;
    rises_o <= !reset_n_i ? 8'h00 : rises_o + {7'h00, irq_i & !irq_ff};
  end
endmodule

// ===== tb/ceim_top_chk.sv
// port assertions for the extended interrupt mask block
`include "ceim_consts.svh"
module ceim_top_chk
  import ceim_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reset_i,
  input wire logic [`CEIM_DATA_W-1:0] event_i,
  input wire logic primary_irq_i,
  input wire ceim_axi_req_t axi_req_i,
  input wire ceim_axi_rsp_t axi_rsp_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_prim; primary_irq_i |=> irq_o; endproperty
  a_prim: assert property (p_prim) else $error("primary lost");
  property p_soft; soft_reset_i ##1 !primary_irq_i [*2] |=> !irq_o; endproperty
  a_soft: assert property (p_soft) else $error("irq after soft reset");
  property p_rsv; axi_rsp_o.rvalid |-> (axi_rsp_o.rdata & ~`CEIM_MASK_IMPL) == 0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read");
  property p_rd; axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read late");
  property p_rhold; axi_rsp_o.rvalid && !axi_req_i.rready |=> $stable(axi_rsp_o.rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  property p_bhold; axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rdone; axi_rsp_o.rvalid && axi_req_i.rready |=> !axi_rsp_o.rvalid && axi_rsp_o.arready; endproperty
  a_rdone: assert property (p_rdone) else $error("read not closed");
  property p_arlow; axi_rsp_o.rvalid |-> !axi_rsp_o.arready; endproperty
  a_arlow: assert property (p_arlow) else $error("arready early");
  c_irq: cover property (irq_o && !primary_irq_i);
  c_wr: cover property (axi_rsp_o.bvalid && axi_req_i.bready);
  c_soft: cover property (soft_reset_i);
endmodule
bind ceim_top ceim_top_chk u_chk (.core_clk_i, .reset_n_i, .soft_reset_i, .event_i,
  .primary_irq_i, .axi_req_i, .axi_rsp_o, .irq_o);

// ===== tb/extended_interrupt_mask_bench.sv
// self-checking bench for the extended interrupt mask block
`include "ceim_consts.svh"
module extended_interrupt_mask_bench
  import ceim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, reset_n_i = 0, soft_reset_i = 0, primary_irq_i = 0, last = 0, irq_o;
  logic [31:0] event_i = '0, fi = `CEIM_FLAG_IMPL, q[$], x, rv;
  ceim_axi_req_t req = '0;
  ceim_axi_rsp_t rsp;
  logic [7:0] rises;
  int fails = 0, checks_done = 0, ups = 0, seed = 88245;
  ceim_top dut (.core_clk_i, .reset_n_i, .soft_reset_i, .event_i, .primary_irq_i,
    .axi_req_i(req), .axi_rsp_o(rsp), .irq_o);
  ceim_host host (.core_clk_i, .reset_n_i, .irq_i(irq_o), .rises_o(rises));
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do @(posedge core_clk_i); while (!(rsp.awready && rsp.wready));
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge core_clk_i); while (!rsp.bvalid);
    chk({30'h0, rsp.bresp}, {30'h0, e});
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    q.push_back(e);
    do @(posedge core_clk_i); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge core_clk_i); while (!rsp.rvalid);
    req.rready <= 1'b0;
  endtask
  task automatic pulse(input logic [31:0] v);
    event_i <= v;
    @(posedge core_clk_i);
    event_i <= '0;
  endtask
  // pin is a level; let writes and events land first
  task automatic irq_is(input logic e);
    repeat (3) @(posedge core_clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
    if (e && !last) ups++;
    last = e;
  endtask
  // read data checked against the oldest note
  always @(posedge core_clk_i) begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      x = q.pop_front();
      chk(rsp.rdata, x);
    end
  end
  // generous cap: the sequence needs under a thousand cycles
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(`CEIM_OFF_MASK, 32'h0);
    wr(`CEIM_OFF_MASK, 32'hffff_ffff, `CEIM_RESP_OKAY);
    rd(`CEIM_OFF_MASK, `CEIM_MASK_IMPL);
    for (int i = 0; i < 32; i++) begin
      wr(`CEIM_OFF_MASK, (32'h1 << i) | 32'h4, `CEIM_RESP_OKAY);
      pulse(32'h1 << i);
      irq_is(fi[i]);
      wr(`CEIM_OFF_STATUS, 32'hffff_ffff, `CEIM_RESP_OKAY);
      irq_is(1'b0);
    end
    rv = $random(seed);
    wr(`CEIM_OFF_MASK, `CEIM_MASK_IMPL & ~32'h4, `CEIM_RESP_OKAY);
    pulse(rv);
    irq_is(1'b0);
    rd(`CEIM_OFF_STATUS, rv & fi);
    wr(`CEIM_OFF_MASK, `CEIM_MASK_IMPL, `CEIM_RESP_OKAY);
    irq_is(|(rv & fi));
    soft_reset_i <= 1'b1;
    @(posedge core_clk_i);
    soft_reset_i <= 1'b0;
    irq_is(1'b0);
    rd(`CEIM_OFF_MASK, 32'h0);
    primary_irq_i <= 1'b1;
    irq_is(1'b1);
    primary_irq_i <= 1'b0;
    irq_is(1'b0);
    wr(8'h40, 32'h1, `CEIM_RESP_SLVERR);
    rd(8'h40, 32'h0);
    chk({24'h0, rises}, ups);
    finish_test();
  end
endmodule
